// ===== osd_pkg.sv
// constants for the oscillation-stop detector and clock generator
`default_nettype none
package osd_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_SOURCE_SEL  = 8'h00;
    localparam logic [7:0] ADDR_DIVIDERS    = 8'h04;
    localparam logic [7:0] ADDR_DETECT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_OSC_CTRL    = 8'h0C;
    localparam logic [7:0] ADDR_DETECT_STAT = 8'h10;
    localparam logic [7:0] ADDR_NMI_ENABLE  = 8'h14;

    // clock source select encodings
    localparam logic [2:0] SRC_SLOW = 3'h0;
    localparam logic [2:0] SRC_FAST = 3'h1;
    localparam logic [2:0] SRC_MAIN = 3'h2;
    localparam logic [2:0] SRC_SUB  = 3'h3;

    // divider register fields
    localparam int SYS_DIV_LSB   = 0;
    localparam int FLASH_DIV_LSB = 4;
    localparam int PB_DIV_LSB    = 8;
    localparam int PD_DIV_LSB    = 12;
    localparam int DIV_W         = 4;

    // detect control fields
    localparam int IRQ_EN_BIT    = 0;
    localparam int DETECT_EN_BIT = 7;

    // oscillator control fields
    localparam int MAIN_STOP_BIT = 0;
    localparam int SUB_STOP_BIT  = 1;
    localparam int RTC_RUN_BIT   = 2;
    localparam int SLOW_STOP_BIT = 3;

    // status and nmi fields
    localparam int STOP_FLAG_BIT = 0;
    localparam int NMI_EN_BIT    = 0;

    // reset values
    localparam logic [2:0]  SOURCE_SEL_RST = 3'h0;
    localparam logic [15:0] DIVIDERS_RST   = 16'h0000;
    localparam logic [3:0]  OSC_CTRL_RST   = 4'h1;

    // stop detection period
    localparam int CORE_CLK_MHZ    = 200;
    localparam int STOP_DETECT_NS  = 1000;
    localparam int STOP_DETECT_CYC = (STOP_DETECT_NS * CORE_CLK_MHZ) / 1000;
endpackage : osd_pkg
`default_nettype wire

// ===== osd_sync.sv
// two-flop synchroniser for asynchronous oscillator levels
`timescale 1ns/1ps
`default_nettype none
module osd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule : osd_sync
`default_nettype wire

// ===== osd_clk_div.sv
// divides a source tick stream into a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module osd_clk_div #(
    parameter int DIV_W = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             srcTick,
    input  wire logic [DIV_W-1:0] divField,
    output logic                  clkEn
);
    logic [DIV_W-1:0] count_q;
    wire              wrapNow = srcTick && (count_q >= divField);

    // a shrunk ratio wraps at once instead of running to overflow
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= '0;
            clkEn   <= 1'b0;
        end else begin
            clkEn <= wrapNow;
            if (wrapNow) begin
                count_q <= '0;
            end else if (srcTick) begin
                count_q <= count_q + 1'b1;
            end
        end
    end
endmodule : osd_clk_div
`default_nettype wire

// ===== osd_clock_gen.sv
// oscillation-stop detector with fallback and derived clock enables
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - flag a stop when main clock input stays constant past the period.
// - on stop, low-speed clock replaces main ahead of source select.
// - fallback is used while flag is 1, main returns when cleared.
// - clearing the flag is ignored while main clock is selected.
// - after reset main oscillator is stopped and detection disabled.
// - fallback applies to system source and frequency-measure main clock.
// - on fallback system clock is low-speed clock over its divider.
// - interrupt when flag becomes 1 while interrupt enable is 1.
// - on detection notify the output-enable unit to set its flag.
// - stop interrupt is non-maskable, disabled until software enables.
// - each derived clock is selected source over its own divider.
// - system, peripheral-b and peripheral-d enables feed their users.
// - flash-interface enable serves rom and data-flash access.
// - frequency measurement gets five oscillator clocks.
// - rtc clock only from sub-clock, watchdog clock from own oscillator.
// - source select code 010b is the main clock.
// - flag clears by reading 1 then writing 0.
// - flag stays 1 after main oscillation resumes until cleared.
// - writing 0 to detect enable ignored while flag; forces slow osc.
module osd_clock_gen #(
    parameter int STOP_CYC = osd_pkg::STOP_DETECT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    // oscillator pins
    input  wire logic        mainOscIn,
    input  wire logic        subOscIn,
    input  wire logic        fastOscIn,
    input  wire logic        slowOscIn,
    input  wire logic        wdtOscIn,
    // oscillator controls
    output logic             mainOscRun,
    output logic             subOscRun,
    output logic             slowOscRun,
    // derived clock enables
    output logic             systemClockEn,
    output logic             flashIfClockEn,
    output logic             periphBClockEn,
    output logic             periphDClockEn,
    // frequency-measurement, rtc and watchdog clocks
    output logic             freqMeasureMainClock,
    output logic             freqMeasureSubClock,
    output logic             freqMeasureFastOscClock,
    output logic             freqMeasureSlowOscClock,
    output logic             freqMeasureWdtOscClock,
    output logic             rtcDedicatedSubclock,
    output logic             indepWatchdogClock,
    // events
    output logic             oscStopInterrupt,
    output logic             poeOscStopNotify,
    output logic             oscStopFlag
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [4:0] oscSync;
    osd_sync #(
        .WIDTH (5)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  ({wdtOscIn, slowOscIn, fastOscIn, subOscIn, mainOscIn}),
        .syncOut  (oscSync)
    );

    wire mainLvl = oscSync[0];
    wire subLvl  = oscSync[1];
    wire fastLvl = oscSync[2];
    wire slowLvl = oscSync[3];
    wire wdtLvl  = oscSync[4];

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [2:0]  sourceSel_q;
    logic [15:0] dividers_q;
    logic        irqEnable_q;
    logic        detectEnable_q;
    logic [3:0]  oscCtrl_q;
    logic        stopFlag_q;
    logic        flagReadOne_q;
    logic        nmiEnable_q;
    logic [31:0] rdata_q;

    wire wrSource = regWrite && (regAddr == osd_pkg::ADDR_SOURCE_SEL);
    wire wrDiv    = regWrite && (regAddr == osd_pkg::ADDR_DIVIDERS);
    wire wrDetect = regWrite && (regAddr == osd_pkg::ADDR_DETECT_CTRL);
    wire wrOsc    = regWrite && (regAddr == osd_pkg::ADDR_OSC_CTRL);
    wire wrStat   = regWrite && (regAddr == osd_pkg::ADDR_DETECT_STAT);
    wire wrNmi    = regWrite && (regAddr == osd_pkg::ADDR_NMI_ENABLE);
    wire rdStat   = regRead && (regAddr == osd_pkg::ADDR_DETECT_STAT);

    wire mainSelected = (sourceSel_q == osd_pkg::SRC_MAIN);

    // clear only after a read of 1, and never while main is selected
    wire clearFlag = wrStat && flagReadOne_q
        && !regWdata[osd_pkg::STOP_FLAG_BIT] && !mainSelected;

    // disabling detection is refused while a stop is flagged
    wire detectEnableD = (wrDetect && !stopFlag_q)
        ? regWdata[osd_pkg::DETECT_EN_BIT] : detectEnable_q;

    ////////////////////////////////////////////////////////////////////////
    // stop detection
    logic [$clog2(STOP_CYC+1)-1:0] quietCount_q;
    logic                          mainLvlPrev_q;
    wire mainEdge   = mainLvl ^ mainLvlPrev_q;
    wire quietLimit = (quietCount_q == ($clog2(STOP_CYC+1))'(STOP_CYC));
    wire stopSeen   = detectEnable_q && quietLimit;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mainLvlPrev_q <= 1'b0;
            quietCount_q  <= '0;
        end else begin
            mainLvlPrev_q <= mainLvl;
            if (mainEdge || !detectEnable_q) begin
                quietCount_q <= '0;
            end else if (!quietLimit) begin
                quietCount_q <= quietCount_q + 1'b1;
            end
        end
    end

    // set wins over clear; flag holds after main resumes
    wire stopFlagD = stopSeen || (stopFlag_q && !clearFlag);
    wire flagRise  = stopFlagD && !stopFlag_q;

    ////////////////////////////////////////////////////////////////////////
    // register write and flag state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sourceSel_q    <= osd_pkg::SOURCE_SEL_RST;
            dividers_q     <= osd_pkg::DIVIDERS_RST;
            irqEnable_q    <= 1'b0;
            detectEnable_q <= 1'b0;
            oscCtrl_q      <= osd_pkg::OSC_CTRL_RST;
            stopFlag_q     <= 1'b0;
            flagReadOne_q  <= 1'b0;
            nmiEnable_q    <= 1'b0;
        end else begin
            if (wrSource) begin
                sourceSel_q <= regWdata[2:0];
            end
            if (wrDiv) begin
                dividers_q <= regWdata[15:0];
            end
            if (wrDetect) begin
                irqEnable_q <= regWdata[osd_pkg::IRQ_EN_BIT];
            end
            detectEnable_q <= detectEnableD;
            if (wrOsc) begin
                oscCtrl_q <= regWdata[3:0];
            end
            stopFlag_q <= stopFlagD;
            if (rdStat) begin
                flagReadOne_q <= stopFlag_q;
            end else if (wrStat) begin
                flagReadOne_q <= 1'b0;
            end
            // once on, only reset turns it off
            if (wrNmi && regWdata[osd_pkg::NMI_EN_BIT]) begin
                nmiEnable_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (regAddr)
            osd_pkg::ADDR_SOURCE_SEL:  rdMux[2:0] = sourceSel_q;
            osd_pkg::ADDR_DIVIDERS:    rdMux[15:0] = dividers_q;
            osd_pkg::ADDR_DETECT_CTRL: begin
                rdMux[osd_pkg::IRQ_EN_BIT]    = irqEnable_q;
                rdMux[osd_pkg::DETECT_EN_BIT] = detectEnable_q;
            end
            osd_pkg::ADDR_OSC_CTRL:    rdMux[3:0] = oscCtrl_q;
            osd_pkg::ADDR_DETECT_STAT: rdMux[osd_pkg::STOP_FLAG_BIT] =
                stopFlag_q;
            osd_pkg::ADDR_NMI_ENABLE:  rdMux[osd_pkg::NMI_EN_BIT] =
                nmiEnable_q;
            default:                   rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= regRead ? rdMux : 32'h0000_0000;
        end
    end
    assign regRdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // oscillator controls
    assign mainOscRun = !oscCtrl_q[osd_pkg::MAIN_STOP_BIT];
    // a clear sub stop bit or a set rtc run bit keeps the sub oscillator running
    assign subOscRun  = !oscCtrl_q[osd_pkg::SUB_STOP_BIT]
        || oscCtrl_q[osd_pkg::RTC_RUN_BIT];
    assign slowOscRun = !oscCtrl_q[osd_pkg::SLOW_STOP_BIT]
        || detectEnable_q;

    ////////////////////////////////////////////////////////////////////////
    // fallback selector and source mux
    logic substitute_q;
    logic mainLvlSel_q;
    logic srcLvlPrev_q;

    // move to the slow clock at once while flagged; switch back only while both clocks sit low, so no runt pulse escapes
    wire safeSwitch = !slowLvl && !mainLvl;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            substitute_q <= 1'b0;
        end else begin
            if (safeSwitch || stopFlag_q) begin
                substitute_q <= stopFlag_q;
            end
        end
    end

    // main clock as seen downstream, with select code left untouched
    wire mainEff = substitute_q ? slowLvl : mainLvl;

    logic srcLvl;
    always_comb begin
        unique case (sourceSel_q)
            osd_pkg::SRC_SLOW: srcLvl = slowLvl;
            osd_pkg::SRC_FAST: srcLvl = fastLvl;
            osd_pkg::SRC_MAIN: srcLvl = mainEff;
            osd_pkg::SRC_SUB:  srcLvl = subLvl;
            default:           srcLvl = slowLvl;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            srcLvlPrev_q <= 1'b0;
            mainLvlSel_q <= 1'b0;
        end else begin
            srcLvlPrev_q <= srcLvl;
            mainLvlSel_q <= mainEff;
        end
    end
    wire srcTick = srcLvl && !srcLvlPrev_q;

    ////////////////////////////////////////////////////////////////////////
    // derived clock enables
    logic [3:0] divEn;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_div
            osd_clk_div #(
                .DIV_W (osd_pkg::DIV_W)
            ) u_div (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .srcTick  (srcTick),
                .divField (dividers_q[gi*osd_pkg::DIV_W +: osd_pkg::DIV_W]),
                .clkEn    (divEn[gi])
            );
        end
    endgenerate

    assign systemClockEn  = divEn[osd_pkg::SYS_DIV_LSB / 4];
    assign flashIfClockEn = divEn[osd_pkg::FLASH_DIV_LSB / 4];
    assign periphBClockEn = divEn[osd_pkg::PB_DIV_LSB / 4];
    assign periphDClockEn = divEn[osd_pkg::PD_DIV_LSB / 4];

    ////////////////////////////////////////////////////////////////////////
    // dedicated clocks
    logic [6:0] dedClk_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dedClk_q <= 7'h00;
        end else begin
            dedClk_q <= {wdtLvl, subLvl && subOscRun, wdtLvl,
                         slowLvl, fastLvl, subLvl, mainLvlSel_q};
        end
    end
    assign freqMeasureMainClock    = dedClk_q[0];
    assign freqMeasureSubClock     = dedClk_q[1];
    assign freqMeasureFastOscClock = dedClk_q[2];
    assign freqMeasureSlowOscClock = dedClk_q[3];
    assign freqMeasureWdtOscClock  = dedClk_q[4];
    assign rtcDedicatedSubclock    = dedClk_q[5];
    assign indepWatchdogClock      = dedClk_q[6];

    ////////////////////////////////////////////////////////////////////////
    // events
    logic irq_q;
    logic poe_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            poe_q <= 1'b0;
        end else begin
            irq_q <= flagRise && irqEnable_q && nmiEnable_q;
            poe_q <= flagRise;
        end
    end
    assign oscStopInterrupt = irq_q;
    assign poeOscStopNotify = poe_q;
    assign oscStopFlag      = stopFlag_q;
endmodule : osd_clock_gen
`default_nettype wire

// ===== osd_osc_model.sv
// behavioural oscillators feeding the clock generator pins
`timescale 1ns/1ps
`default_nettype none
module osd_osc_model (
    input  wire logic mainRun,
    input  wire logic subRun,
    input  wire logic slowRun,
    input  wire logic mainStall,
    output logic      mainOsc,
    output logic      subOsc,
    output logic      fastOsc,
    output logic      slowOsc,
    output logic      wdtOsc
);
    initial begin
        mainOsc = 1'b0;
        subOsc  = 1'b0;
        fastOsc = 1'b0;
        slowOsc = 1'b0;
        wdtOsc  = 1'b0;
    end
    ////////////////////////////////////////
    // a stopped or stalled oscillator holds its level, as a dead crystal does
    always #12 if (mainRun && !mainStall) mainOsc = !mainOsc;
    always #30 if (subRun) subOsc = !subOsc;
    always #11 fastOsc = !fastOsc;
    always #40 if (slowRun) slowOsc = !slowOsc;
    always #25 wdtOsc = !wdtOsc;
endmodule : osd_osc_model
`default_nettype wire

// ===== osd_clock_gen_properties.sv
// checker on the oscillation-stop clock generator ports
`timescale 1ns/1ps
`default_nettype none
module osd_chk #(
    parameter int STOP_CYC = 8
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        mainOscIn,
    input wire logic        mainOscRun,
    input wire logic        subOscRun,
    input wire logic        slowOscRun,
    input wire logic        oscStopInterrupt,
    input wire logic        poeOscStopNotify,
    input wire logic        oscStopFlag
);
    logic        irqEn_q, nmiEn_q, detEn_q, mainPrev_q;
    logic [2:0]  src_q;
    logic [15:0] stable_q, run_q;
    wire logic   ctlWr = regWrite && regAddr == osd_pkg::ADDR_DETECT_CTRL;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqEn_q <= 1'b0;
            nmiEn_q <= 1'b0;
            detEn_q <= 1'b0;
            src_q   <= osd_pkg::SOURCE_SEL_RST;
        end else begin
            if (ctlWr)
                irqEn_q <= regWdata[0];
            // zero write refused while flagged
            if (ctlWr && (regWdata[7] || !oscStopFlag))
                detEn_q <= regWdata[7];
            if (regWrite && regAddr == osd_pkg::ADDR_NMI_ENABLE)
                nmiEn_q <= nmiEn_q | regWdata[0];
            if (regWrite && regAddr == osd_pkg::ADDR_SOURCE_SEL)
                src_q <= regWdata[2:0];
        end
    end
    // raw pin run length; longer than the synced view, so a safe bound
    always_ff @(posedge core_clk) begin
        mainPrev_q <= mainOscIn;
        if (!rst_n || mainOscIn != mainPrev_q) begin
            run_q    <= rst_n ? stable_q : 16'h0000;
            stable_q <= 16'h0000;
        end else if (stable_q != 16'hFFFF) begin
            stable_q <= stable_q + 16'h0001;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    chk_reset_state: assert property (
        $rose(rst_n) |-> !mainOscRun && subOscRun && !oscStopFlag)
        else $error("bad state after reset");
    chk_clear_cause: assert property (
        $fell(oscStopFlag) |-> $past(regWrite) && !$past(regWdata[0])
            && $past(regAddr) == osd_pkg::ADDR_DETECT_STAT)
        else $error("flag fell without status write");
    chk_clear_blocked: assert property (
        $fell(oscStopFlag) |-> $past(src_q) != osd_pkg::SRC_MAIN)
        else $error("flag cleared with main selected");
    chk_irq_on_rise: assert property (
        $rose(oscStopFlag) && $past(irqEn_q) && $past(nmiEn_q)
            |-> oscStopInterrupt)
        else $error("missing stop interrupt");
    chk_irq_cause: assert property (
        oscStopInterrupt |-> oscStopFlag && !$past(oscStopFlag)
            && $past(irqEn_q) && $past(nmiEn_q))
        else $error("stray stop interrupt");
    chk_poe_notify: assert property (
        $rose(oscStopFlag) |-> poeOscStopNotify)
        else $error("missing output-enable notify");
    chk_detect_gate: assert property (
        $rose(oscStopFlag) |-> $past(detEn_q))
        else $error("stop flagged while detection off");
    chk_detect_time: assert property (
        $rose(oscStopFlag) |-> int'(stable_q) >= STOP_CYC
            || int'(run_q) >= STOP_CYC)
        else $error("stop flagged too early");
    chk_slow_forced: assert property (
        detEn_q |-> slowOscRun)
        else $error("slow oscillator off during detection");
    chk_read_flag: assert property (
        regRead && regAddr == osd_pkg::ADDR_DETECT_STAT |=>
            regRdata == {31'h0, $past(oscStopFlag)})
        else $error("status read wrong");
    cov_stop: cover property ($rose(oscStopFlag));
    cov_irq: cover property (oscStopInterrupt);
    cov_clear: cover property ($fell(oscStopFlag));
endmodule : osd_chk
bind osd_clock_gen osd_chk #(.STOP_CYC(STOP_CYC)) u_osd_chk (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .mainOscIn(mainOscIn), .mainOscRun(mainOscRun),
    .subOscRun(subOscRun), .slowOscRun(slowOscRun),
    .oscStopInterrupt(oscStopInterrupt),
    .poeOscStopNotify(poeOscStopNotify), .oscStopFlag(oscStopFlag)
);
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the oscillation-stop clock generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] SRC = osd_pkg::ADDR_SOURCE_SEL;
    localparam logic [7:0] CTL = osd_pkg::ADDR_DETECT_CTRL;
    localparam logic [7:0] OSC = osd_pkg::ADDR_OSC_CTRL;
    localparam logic [7:0] STA = osd_pkg::ADDR_DETECT_STAT;
    logic        core_clk, rst_n, regWrite, regRead, mainStall;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, d;
    logic        mainOscIn, subOscIn, fastOscIn, slowOscIn, wdtOscIn;
    logic        mainOscRun, subOscRun, slowOscRun, systemClockEn;
    logic        flashIfClockEn, periphBClockEn, periphDClockEn;
    logic        freqMeasureMainClock, freqMeasureSubClock;
    logic        freqMeasureFastOscClock, freqMeasureSlowOscClock;
    logic        freqMeasureWdtOscClock, rtcDedicatedSubclock;
    logic        indepWatchdogClock, oscStopInterrupt, poeOscStopNotify;
    logic        oscStopFlag;
    logic [13:0] watch, watchPrev;
    int          edges [14];
    int          irqCnt, poeCnt, errCount, testsRun;
    osd_clock_gen #(.STOP_CYC(8)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .mainOscIn(mainOscIn), .subOscIn(subOscIn),
        .fastOscIn(fastOscIn), .slowOscIn(slowOscIn), .wdtOscIn(wdtOscIn),
        .mainOscRun(mainOscRun), .subOscRun(subOscRun),
        .slowOscRun(slowOscRun), .systemClockEn(systemClockEn),
        .flashIfClockEn(flashIfClockEn), .periphBClockEn(periphBClockEn),
        .periphDClockEn(periphDClockEn),
        .freqMeasureMainClock(freqMeasureMainClock),
        .freqMeasureSubClock(freqMeasureSubClock),
        .freqMeasureFastOscClock(freqMeasureFastOscClock),
        .freqMeasureSlowOscClock(freqMeasureSlowOscClock),
        .freqMeasureWdtOscClock(freqMeasureWdtOscClock),
        .rtcDedicatedSubclock(rtcDedicatedSubclock),
        .indepWatchdogClock(indepWatchdogClock),
        .oscStopInterrupt(oscStopInterrupt),
        .poeOscStopNotify(poeOscStopNotify), .oscStopFlag(oscStopFlag)
    );
    osd_osc_model osc (
        .mainRun(mainOscRun), .subRun(subOscRun), .slowRun(slowOscRun),
        .mainStall(mainStall), .mainOsc(mainOscIn), .subOsc(subOscIn),
        .fastOsc(fastOscIn), .slowOsc(slowOscIn), .wdtOsc(wdtOscIn)
    );
    ////////////////////////////////////////
    assign watch = {mainOscIn, indepWatchdogClock, rtcDedicatedSubclock,
        freqMeasureWdtOscClock, freqMeasureSlowOscClock,
        freqMeasureFastOscClock, freqMeasureSubClock, freqMeasureMainClock,
        periphDClockEn, periphBClockEn, flashIfClockEn, systemClockEn,
        slowOscIn, fastOscIn};
    always @(posedge core_clk) begin
        watchPrev <= watch;
        for (int i = 0; i < 14; i++) edges[i] += (watch[i] & ~watchPrev[i]);
        if (oscStopInterrupt === 1'b1) irqCnt++;
        if (poeOscStopNotify === 1'b1) poeCnt++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // divider phase and synchroniser lag allow one edge of slack
    task automatic near(input int seen, input int exp);
        check({31'h0, seen - exp <= 1 && exp - seen <= 1}, 32'h1);
    endtask : near
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask : rd
    task automatic countFor(input int n);
        #1 foreach (edges[i]) edges[i] = 0;
        repeat (n) @(posedge core_clk);
    endtask : countFor
    task automatic t_reset;
        #1 check({30'h0, mainOscRun, oscStopFlag}, 32'h0);
        rd(OSC, d);
        check(d, 32'h1);
        rd(CTL, d);
        check(d, 32'h0);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, d);
        check(d, 32'h0);
        wr(OSC, 32'h2);
        #1 check({30'h0, mainOscRun, subOscRun}, 32'h2);
        repeat (20) @(posedge core_clk);
        $display("reset test done");
    endtask : t_reset
    task automatic t_divide;
        wr(SRC, {29'h0, osd_pkg::SRC_FAST});
        wr(osd_pkg::ADDR_DIVIDERS, 32'h7310);
        countFor(400);
        near(edges[2], edges[0]);
        near(edges[3], edges[0] / 2);
        near(edges[4], edges[0] / 4);
        near(edges[5], edges[0] / 8);
        $display("divider test done");
    endtask : t_divide
    task automatic t_clocks;
        countFor(200);
        check({31'h0, edges[11] == 0 && edges[12] > 0}, 32'h1);
        for (int i = 8; i <= 10; i++) check(32'(edges[i] > 0), 32'h1);
        wr(OSC, 32'h0);
        countFor(200);
        near(edges[11], edges[7]);
        near(edges[6], edges[13]);
        wr(OSC, 32'h2);
        $display("clock source test done");
    endtask : t_clocks
    task automatic t_stop;
        wr(osd_pkg::ADDR_NMI_ENABLE, 32'h1);
        wr(CTL, 32'h81);
        wr(SRC, {29'h0, osd_pkg::SRC_MAIN});
        repeat (50) @(posedge core_clk);
        #1 check({31'h0, oscStopFlag}, 32'h0);
        irqCnt = 0;
        poeCnt = 0;
        mainStall = 1'b1;
        for (int n = 0; oscStopFlag !== 1'b1; n++) begin
            if (n == 200) begin
                errCount++;
                $display("unexpected at %0t: no stop flagged", $time);
                tally_and_finish;
            end
            @(posedge core_clk);
        end
        countFor(300);
        check({30'h0, irqCnt[0], poeCnt[0]}, 32'h3);
        near(edges[2], edges[1]);
        check({31'h0, edges[6] > 0 && slowOscRun}, 32'h1);
        wr(CTL, 32'h01);
        rd(CTL, d);
        check(d, 32'h81);
        rd(STA, d);
        check(d, 32'h1);
        wr(STA, 32'h0);
        mainStall = 1'b0;
        repeat (50) @(posedge core_clk);
        #1 check({31'h0, oscStopFlag}, 32'h1);
        wr(CTL, 32'h80);
        wr(SRC, {29'h0, osd_pkg::SRC_SLOW});
        wr(STA, 32'h0);
        repeat (3) @(posedge core_clk);
        #1 check({31'h0, oscStopFlag}, 32'h1);
        rd(STA, d);
        wr(STA, 32'h0);
        repeat (3) @(posedge core_clk);
        rd(STA, d);
        check(d, 32'h0);
        repeat (150) @(posedge core_clk);
        wr(CTL, 32'h81);
        wr(SRC, {29'h0, osd_pkg::SRC_MAIN});
        countFor(200);
        near(edges[2], edges[13]);
        check(32'(irqCnt), 32'h1);
        wr(CTL, 32'h0);
        wr(OSC, 32'h3);
        repeat (50) @(posedge core_clk);
        #1 check({30'h0, mainOscRun, oscStopFlag}, 32'h0);
        $display("stop detection test done");
    endtask : t_stop
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        rst_n = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        mainStall = 1'b0;
        errCount = 0;
        testsRun = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_divide;
        t_clocks;
        t_stop;
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
